/* File: verilog/psc_config_bank.sv */
// Power sequence configuration bank with sequencer-facing decode
// What this block does
// - Up steps 1-4 hold until power good
// - Down step delays 0, 2, 5, 10 ms
// - Main regulator down delay 2-20 ms
// - Sleep level sets failsafe pin level
// - Boost kill bit forces boost off
// - Programming status bits writable by NVM only
// - Release id writable only in emulation
// - Checksum split across upper and middle bytes
// - Boost good threshold 5.5 to 8.5 V
// - Bypass offset 1.0 or 0.5 V
// - Boost level 6 to 9 V
// - Pending wake flag blocks deep sleep
// - Each register carries a check nibble
// - Boost timer field and crank enable bit
// - Up steps 5-7 hold until power good
// - Boost timer codes 0 to 10 s
// - Crank only bit enables cranking boost
// - Supply sense 5.4 to 5.85 V
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "psc_defines.svh"
module psc_config_bank #(
   parameter logic [14:0] MS_CYCLES = 15'(`PSC_CYC_PER_MS)
) (
   input  wire logic                core_clk_i,        // 20 MHz clock
   input  wire logic                reset_i,           // Synchronous reset
   input  wire logic [7:0]          reg_addr_i,        // Register index
   input  wire psc_pkg::psc_word_t  reg_wdata_i,       // Write data
   input  wire logic                reg_wr_i,          // Write strobe
   input  wire logic                reg_rd_i,          // Read strobe
   output psc_pkg::psc_word_t       reg_rdata_o,       // Read data, next cycle
   input  wire logic                user_prog_phase_one_i, // Emulation allowed
   input  wire logic                nvm_we_i,          // NVM controller load
   input  wire logic [7:0]          nvm_addr_i,        // NVM load index
   input  wire psc_pkg::psc_word_t  nvm_data_i,        // NVM load word
   input  wire logic [2:0]          up_step_i,         // Current up step, 0 none
   input  wire logic                power_good_i,      // Power-good pin
   output logic                     up_hold_o,         // Hold at this step
   input  wire logic                down_start_i,      // Start a down delay
   input  wire logic [2:0]          down_step_i,       // Down step, 0 main reg
   output logic                     down_busy_o,       // Delay running
   output logic                     down_done_o,       // Delay finished pulse
   input  wire logic                deep_sleep_i,      // FSM in deep sleep
   input  wire logic                failsafe_req_n_i,  // Level outside sleep
   output logic                     failsafe_out_n_o,  // Failsafe pin level
   input  wire logic                boost_off_i,       // Runtime boost off
   output logic                     boost_en_o,        // Boost allowed
   output logic                     boost_crank_only_o,// Crank boost enabled
   output psc_pkg::psc_mv_t         boost_timer_ms_o,  // Boost timeout, ms
   output psc_pkg::psc_mv_t         boost_good_mv_o,   // Boost good level
   output psc_pkg::psc_mv_t         boost_level_mv_o,  // Boost regulation
   output psc_pkg::psc_mv_t         bypass_mv_o,       // Bypass threshold
   output psc_pkg::psc_mv_t         supply_sense_mv_o, // Supply sense level
   input  wire logic                sleep_req_i,       // Deep sleep request
   input  wire logic                wake_flag_i,       // Wake flag pending
   output logic                     sleep_grant_o,     // Deep sleep allowed
   output logic [15:0]              user_image_release_o,  // Release id
   output logic [7:0]               user_image_checksum_o, // Image checksum
   output logic [1:0]               user_prog_state_bits_o,// Prog status
   output logic [4:0]               crc_err_o          // Check mismatch per reg
);
   import psc_pkg::*;

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (reset_i);

   // ------------------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------------------
   psc_word_t bank [0:`PSC_NREG-1];
   psc_word_t next_bank [0:`PSC_NREG-1];
   psc_word_t rdata, next_rdata;
   psc_cfg_s  cfg, next_cfg;
   logic [2:0] pg_sync, next_pg_sync;
   logic       pg_q, next_pg_q;
   logic [4:0] crc_bad;

   psc_tmr_if tmr ();

   // Check nibble over the twenty stored bits above it
   function automatic logic [3:0] crc4(input logic [19:0] d);
      logic [3:0] c;
      logic       fb;
      c = `PSC_CRC_SEED;
      for (int i = 19; i >= 0; i--) begin
         fb = c[3] ^ d[i];
         c  = {c[2:0], 1'b0} ^ (fb ? `PSC_CRC_POLY : 4'h0);
      end
      return c;
   endfunction

   // Index of an address inside the bank, or out of range
   function automatic logic [`PSC_IDX_W:0] reg_idx(input logic [7:0] a);
      logic [7:0] off;
      off = a - `PSC_ADDR_UPWAIT;
      if (a >= `PSC_ADDR_UPWAIT && a <= `PSC_ADDR_BOOST) begin
         return {1'b1, off[`PSC_IDX_W-1:0]};
      end
      return '0;
   endfunction

   // Step delay codes: 0, 2, 5, 10 ms
   function automatic logic [4:0] step_ms(input logic [1:0] c);
      case (c)
         2'b00:   return `PSC_T0_MS;
         2'b01:   return `PSC_T2_MS;
         2'b10:   return `PSC_T5_MS;
         default: return `PSC_T10_MS;
      endcase
   endfunction

   // ------------------------------------------------------------------------
   // Register writes
   // ------------------------------------------------------------------------
   // NVM load wins over a software write in the same cycle; software only
   // reaches the bank while emulation is open, and never the status bits
   logic [`PSC_IDX_W:0] nvm_ix, bus_ix;
   psc_word_t           bus_w;
   always_comb begin
      nvm_ix = reg_idx(nvm_addr_i);
      bus_ix = reg_idx(reg_addr_i);
      bus_w  = reg_wdata_i & `PSC_STORE_MSK;
      for (int i = 0; i < `PSC_NREG; i++) begin
         next_bank[i] = bank[i];
      end
      if (nvm_we_i && nvm_ix[`PSC_IDX_W]) begin
         next_bank[nvm_ix[`PSC_IDX_W-1:0]] = nvm_data_i & `PSC_STORE_MSK;
      end else if (reg_wr_i && user_prog_phase_one_i && bus_ix[`PSC_IDX_W]) begin
         if (bus_ix[`PSC_IDX_W-1:0] == 3'(`PSC_ADDR_CSUM - `PSC_ADDR_UPWAIT)) begin
            bus_w = (bus_w & ~`PSC_PROG_MSK) | (bank[1] & `PSC_PROG_MSK);
         end
         next_bank[bus_ix[`PSC_IDX_W-1:0]] = bus_w;
      end
   end

   // Bank registers; NVM refills them after reset
   always_ff @(posedge core_clk_i) begin
      for (int i = 0; i < `PSC_NREG; i++) begin
         if (reset_i) begin
            bank[i] <= `PSC_RST_WORD;
         end else begin
            bank[i] <= next_bank[i];
         end
      end
   end

   // ------------------------------------------------------------------------
   // Register reads
   // ------------------------------------------------------------------------
   // Unmapped indices read as zero
   always_comb begin
      next_rdata = rdata;
      if (reg_rd_i) begin
         next_rdata = bus_ix[`PSC_IDX_W] ? bank[bus_ix[`PSC_IDX_W-1:0]] : '0;
      end
   end

   // Read data register
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         rdata <= '0;
      end else begin
         rdata <= next_rdata;
      end
   end

   assign reg_rdata_o = rdata;

   // ------------------------------------------------------------------------
   // Check nibble per register
   // ------------------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < `PSC_NREG; g++) begin : g_crc
         assign crc_bad[g] = crc4(bank[g][23:`PSC_DATA_LO]) != bank[g][`PSC_CRC_HI:0];
      end
   endgenerate

   // ------------------------------------------------------------------------
   // Power-good pin synchroniser
   // ------------------------------------------------------------------------
   // Level changes only once the last two stages agree, filtering glitches
   always_comb begin
      next_pg_sync = {pg_sync[1:0], power_good_i};
      next_pg_q    = (pg_sync[1] == pg_sync[2]) ? pg_sync[2] : pg_q;
   end

   // Synchroniser registers
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         pg_sync <= '0;
         pg_q    <= 1'b0;
      end else begin
         pg_sync <= next_pg_sync;
         pg_q    <= next_pg_q;
      end
   end

   // ------------------------------------------------------------------------
   // Power-down delays
   // ------------------------------------------------------------------------
   // A start while a delay runs is ignored; the sequencer waits for done
   always_comb begin
      tmr.start = down_start_i && !tmr.busy;
      if (down_step_i == 3'd0) begin
         case (bank[2][`PSC_MAIN_REGULATOR_LO +: 2])
            2'b00:   tmr.ms = `PSC_T2_MS;
            2'b01:   tmr.ms = `PSC_T5_MS;
            2'b10:   tmr.ms = `PSC_T10_MS;
            default: tmr.ms = `PSC_T20_MS;
         endcase
      end else begin
         tmr.ms = step_ms(bank[2][`PSC_DN_LO + 2 * (down_step_i - 3'd1) +: 2]);
      end
   end

   psc_delay_timer #(.MS_CYCLES(MS_CYCLES)) u_timer (
      .core_clk_i (core_clk_i),
      .reset_i    (reset_i),
      .tmr_if     (tmr.tmr)
   );

   assign down_busy_o = tmr.busy;
   assign down_done_o = tmr.done;

   // ------------------------------------------------------------------------
   // Decoded configuration outputs
   // ------------------------------------------------------------------------
   always_comb begin
      next_cfg = cfg;
      next_cfg.up_hold = (up_step_i != 3'd0)
         && bank[0][`PSC_UPW_LO + 32'(up_step_i) - 1] && !pg_q;
      next_cfg.failsafe_n = deep_sleep_i ? bank[1][`PSC_FS_BIT] : failsafe_req_n_i;
      next_cfg.boost_en = !bank[1][`PSC_KILL_BIT] && !boost_off_i;
      next_cfg.crank_only = bank[4][`PSC_CRK_BIT];
      case (bank[4][`PSC_TMR_LO +: 3])
         3'd0:    next_cfg.timer_ms = '0;
         3'd1:    next_cfg.timer_ms = `PSC_BT1_MS;
         3'd2:    next_cfg.timer_ms = `PSC_BT2_MS;
         3'd3:    next_cfg.timer_ms = `PSC_BT3_MS;
         3'd4:    next_cfg.timer_ms = `PSC_BT4_MS;
         3'd5:    next_cfg.timer_ms = `PSC_BT5_MS;
         3'd6:    next_cfg.timer_ms = `PSC_BT6_MS;
         default: next_cfg.timer_ms = `PSC_BT7_MS;
      endcase
      next_cfg.good_mv = `PSC_GOOD_BASE
         + 14'(bank[4][`PSC_GOOD_LO +: 2]) * `PSC_VSTEP;
      next_cfg.level_mv = `PSC_LVL_BASE
         + 14'(bank[4][`PSC_LVL_LO +: 2]) * `PSC_VSTEP;
      next_cfg.bypass_mv = next_cfg.level_mv
         + (bank[4][`PSC_BYP_BIT] ? `PSC_BYP_HI : `PSC_BYP_LO);
      next_cfg.sense_mv = `PSC_SNS_BASE
         + 14'(bank[4][`PSC_SNS_LO +: 2]) * `PSC_SNS_STEP;
      next_cfg.sleep_grant = sleep_req_i
         && !(bank[4][`PSC_INH_BIT] && wake_flag_i);
      next_cfg.release_id = bank[3][`PSC_REL_HI:`PSC_REL_LO];
      next_cfg.checksum = bank[1][`PSC_CSUM_HI:`PSC_CSUM_LO];
      next_cfg.prog = bank[1][`PSC_PROG_HI:`PSC_PROG_LO];
      next_cfg.crc_err = crc_bad;
   end

   // Output registers; failsafe idles high until configured
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         cfg            <= '0;
         cfg.failsafe_n <= 1'b1;
      end else begin
         cfg <= next_cfg;
      end
   end

   assign up_hold_o              = cfg.up_hold;
   assign failsafe_out_n_o       = cfg.failsafe_n;
   assign boost_en_o             = cfg.boost_en;
   assign boost_crank_only_o     = cfg.crank_only;
   assign boost_timer_ms_o       = cfg.timer_ms;
   assign boost_good_mv_o        = cfg.good_mv;
   assign boost_level_mv_o       = cfg.level_mv;
   assign bypass_mv_o            = cfg.bypass_mv;
   assign supply_sense_mv_o      = cfg.sense_mv;
   assign sleep_grant_o          = cfg.sleep_grant;
   assign user_image_release_o   = cfg.release_id;
   assign user_image_checksum_o  = cfg.checksum;
   assign user_prog_state_bits_o = cfg.prog;
   assign crc_err_o              = cfg.crc_err;

   // ------------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------------
   a_hold_no_good: assert property (
      (up_step_i == 3'd2 && bank[0][5] && !pg_q) |=> up_hold_o)
      else $error("step did not hold without power good");
   a_hold_skip: assert property (
      (up_step_i == 3'd6 && !bank[0][9]) |=> !up_hold_o)
      else $error("step held with wait disabled");
   a_failsafe_sleep: assert property (
      deep_sleep_i |=> failsafe_out_n_o == $past(bank[1][7]))
      else $error("failsafe level wrong in sleep");
   a_boost_kill: assert property (
      bank[1][4] |=> !boost_en_o)
      else $error("boost enabled while killed");
   a_prog_guard: assert property (
      (reg_wr_i && !nvm_we_i) |=> bank[1][11:10] == $past(bank[1][11:10]))
      else $error("software changed status bits");
   a_emul_only: assert property (
      (!user_prog_phase_one_i && !nvm_we_i) |=> bank[3] == $past(bank[3]))
      else $error("release changed outside emulation");
   a_level_map: assert property (
      (bank[4][16:15] == 2'b11) |=> boost_level_mv_o == 14'd9000)
      else $error("boost level decode wrong");
   a_sleep_block: assert property (
      (bank[4][14] && wake_flag_i) |=> !sleep_grant_o)
      else $error("sleep granted with wake pending");
   a_reserved_zero: assert property (
      reg_rd_i |=> reg_rdata_o[23:20] == 4'h0)
      else $error("reserved bits read nonzero");
   a_main_delay: assert property (
      (down_start_i && !down_busy_o && down_step_i == 3'd0) |-> tmr.ms >= 5'd2)
      else $error("main regulator delay below 2 ms");
endmodule

/* File: verilog/psc_defines.svh */
// Offsets, field positions, reset values and timing figures of the power sequence bank
`ifndef PSC_DEFINES_SVH
`define PSC_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register offsets (register index on the plain port)
// ----------------------------------------------------------------------------
`define PSC_ADDR_UPWAIT   8'h10
`define PSC_ADDR_CSUM     8'h11
`define PSC_ADDR_DOWN     8'h12
`define PSC_ADDR_REL      8'h13
`define PSC_ADDR_BOOST    8'h14
`define PSC_NREG          5
`define PSC_IDX_W         3

// ----------------------------------------------------------------------------
// Masks and reset values
// ----------------------------------------------------------------------------
`define PSC_STORE_MSK     24'h0fffff
`define PSC_PROG_MSK      24'h000c00
`define PSC_RST_WORD      24'h000000

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PSC_UPW_LO        4
`define PSC_CSUM_HI       19
`define PSC_CSUM_LO       12
`define PSC_PROG_HI       11
`define PSC_PROG_LO       10
`define PSC_FS_BIT        7
`define PSC_KILL_BIT      4
`define PSC_MAIN_REGULATOR_LO       18
`define PSC_DN_LO         4
`define PSC_REL_HI        19
`define PSC_REL_LO        4
`define PSC_GOOD_LO       18
`define PSC_BYP_BIT       17
`define PSC_LVL_LO        15
`define PSC_INH_BIT       14
`define PSC_TMR_LO        11
`define PSC_CRK_BIT       10
`define PSC_SNS_LO        8
`define PSC_CRC_HI        3
`define PSC_DATA_LO       4

// ----------------------------------------------------------------------------
// Check nibble: polynomial x^4+x+1, seed all ones
// ----------------------------------------------------------------------------
`define PSC_CRC_POLY      4'h3
`define PSC_CRC_SEED      4'hf

// ----------------------------------------------------------------------------
// Times
// ----------------------------------------------------------------------------
`define PSC_CLK_HZ        20000000
`define PSC_MS_PER_S      1000
`define PSC_CYC_PER_MS    (`PSC_CLK_HZ / `PSC_MS_PER_S)
`define PSC_T0_MS         5'd0
`define PSC_T2_MS         5'd2
`define PSC_T5_MS         5'd5
`define PSC_T10_MS        5'd10
`define PSC_T20_MS        5'd20
`define PSC_BT1_MS        14'd500
`define PSC_BT2_MS        14'd1000
`define PSC_BT3_MS        14'd2000
`define PSC_BT4_MS        14'd4000
`define PSC_BT5_MS        14'd6000
`define PSC_BT6_MS        14'd8000
`define PSC_BT7_MS        14'd10000

// ----------------------------------------------------------------------------
// Thresholds in millivolts
// ----------------------------------------------------------------------------
`define PSC_GOOD_BASE     14'd5500
`define PSC_LVL_BASE      14'd6000
`define PSC_VSTEP         14'd1000
`define PSC_BYP_LO        14'd500
`define PSC_BYP_HI        14'd1000
`define PSC_SNS_BASE      14'd5400
`define PSC_SNS_STEP      14'd150

`endif

/* File: verilog/psc_pkg.sv */
// Types shared by the power sequence configuration bank
package psc_pkg;
   typedef logic [23:0] psc_word_t;
   typedef logic [13:0] psc_mv_t;
   typedef enum logic {TMR_IDLE, TMR_RUN} psc_tmr_state_e;
   typedef struct packed {
      logic        up_hold;
      logic        failsafe_n;
      logic        boost_en;
      logic        crank_only;
      psc_mv_t     timer_ms;
      psc_mv_t     good_mv;
      psc_mv_t     level_mv;
      psc_mv_t     bypass_mv;
      psc_mv_t     sense_mv;
      logic        sleep_grant;
      logic [15:0] release_id;
      logic [7:0]  checksum;
      logic [1:0]  prog;
      logic [4:0]  crc_err;
   } psc_cfg_s;
endpackage

/* File: verilog/psc_tmr_if.sv */
// Link between the bank and its power-down delay timer
`timescale 1ns/1ps
interface psc_tmr_if;
   logic       start;
   logic [4:0] ms;
   logic       done;
   logic       busy;
   modport ctl (output start, output ms, input done, input busy);
   modport tmr (input start, input ms, output done, output busy);
endinterface

/* File: verilog/psc_delay_timer.sv */
// Millisecond delay timer for one power-down step
`timescale 1ns/1ps
`include "psc_defines.svh"
module psc_delay_timer #(
   parameter logic [14:0] MS_CYCLES = 15'(`PSC_CYC_PER_MS)
) (
   input  wire logic core_clk_i,  // 20 MHz clock
   input  wire logic reset_i,     // Synchronous reset
   psc_tmr_if.tmr    tmr_if       // Start and completion
);
   import psc_pkg::*;

   psc_tmr_state_e state, next_state;
   logic [14:0]    pre, next_pre;
   logic [4:0]     left, next_left;
   logic           done, next_done;

   // ------------------------------------------------------------------------
   // Delay sequencing
   // ------------------------------------------------------------------------
   // A zero delay finishes on the next edge so the step advances at once
   always_comb begin
      next_state = state;
      next_pre   = pre;
      next_left  = left;
      next_done  = 1'b0;
      case (state)
         TMR_IDLE: begin
            if (tmr_if.start) begin
               if (tmr_if.ms == `PSC_T0_MS) begin
                  next_done = 1'b1;
               end else begin
                  next_state = TMR_RUN;
                  next_left  = tmr_if.ms;
                  next_pre   = '0;
               end
            end
         end
         TMR_RUN: begin
            if (pre == MS_CYCLES - 15'd1) begin
               next_pre = '0;
               if (left == 5'd1) begin
                  next_done  = 1'b1;
                  next_state = TMR_IDLE;
               end else begin
                  next_left = left - 5'd1;
               end
            end else begin
               next_pre = pre + 15'd1;
            end
         end
         default: next_state = TMR_IDLE;
      endcase
   end

   // Registers of the timer
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         state <= TMR_IDLE;
         pre   <= '0;
         left  <= '0;
         done  <= 1'b0;
      end else begin
         state <= next_state;
         pre   <= next_pre;
         left  <= next_left;
         done  <= next_done;
      end
   end

   assign tmr_if.done = done;
   assign tmr_if.busy = (state == TMR_RUN);

   // ------------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------------
   a_zero_delay: assert property (@(posedge core_clk_i) disable iff (reset_i)
      (tmr_if.start && !tmr_if.busy && tmr_if.ms == 5'd0) |=> (done && !tmr_if.busy))
      else $error("zero delay did not finish next cycle");
   a_busy_ends: assert property (@(posedge core_clk_i) disable iff (reset_i)
      $fell(tmr_if.busy) |-> done)
      else $error("delay ended without done");
endmodule

/* File: sim/psc_nvm_model.sv */
// Behavioural NVM controller that loads whole words into the bank
`timescale 1ns/1ps
module psc_nvm_model (
   input  wire logic        core_clk_i, // Bank clock
   output logic             nvm_we_o,   // Load strobe
   output logic [7:0]       nvm_addr_o, // Load index
   output logic [23:0]      nvm_data_o  // Load word
);
   initial begin
      nvm_we_o = 1'b0;
      nvm_addr_o = 8'h00;
      nvm_data_o = 24'h000000;
   end
   // One-cycle load; data inverted after so a stale word is never trusted
   task automatic load(input logic [7:0] a, input logic [23:0] d);
      @(posedge core_clk_i);
      nvm_we_o <= 1'b1;
      nvm_addr_o <= a;
      nvm_data_o <= d;
      @(posedge core_clk_i);
      nvm_we_o <= 1'b0;
      nvm_data_o <= ~d;
   endtask
endmodule

/* File: sim/tb_psc_config_bank.sv */
// Self-checking bench for the power sequence configuration bank
`timescale 1ns/1ps
module tb_psc_config_bank;
   import psc_pkg::*;
   logic        core_clk_i = 1'b0, reset_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
   logic        user_prog_phase_one_i = 1'b0, nvm_we_i, power_good_i = 1'b0, down_start_i = 1'b0;
   logic        deep_sleep_i = 1'b0, failsafe_req_n_i = 1'b1, boost_off_i = 1'b0;
   logic        sleep_req_i = 1'b0, wake_flag_i = 1'b0;
   logic [7:0]  reg_addr_i = 8'h00, nvm_addr_i, user_image_checksum_o;
   logic [2:0]  up_step_i = 3'h0, down_step_i = 3'h0;
   psc_word_t   reg_wdata_i = 24'h000000, nvm_data_i, reg_rdata_o;
   logic        up_hold_o, down_busy_o, down_done_o, failsafe_out_n_o, boost_en_o;
   logic        boost_crank_only_o, sleep_grant_o;
   psc_mv_t     boost_timer_ms_o, boost_good_mv_o, boost_level_mv_o, bypass_mv_o, supply_sense_mv_o;
   logic [15:0] user_image_release_o;
   logic [1:0]  user_prog_state_bits_o;
   logic [4:0]  crc_err_o;
   int          bad_count = 0, checks = 0;
   psc_mv_t     tmr_tab [8] = '{0, 500, 1000, 2000, 4000, 6000, 8000, 10000};

   // Short millisecond keeps the 20 ms delay at 80 cycles
   psc_config_bank #(.MS_CYCLES(15'd4)) psc_config_bank_i (.*);
   psc_nvm_model psc_nvm_model_i (.core_clk_i, .nvm_we_o(nvm_we_i), .nvm_addr_o(nvm_addr_i),
                                  .nvm_data_o(nvm_data_i));

   always #25 core_clk_i = ~core_clk_i;

   // ---------------------------------------------------------------
   // Bus and compare helpers
   // ---------------------------------------------------------------
   task automatic chk(input logic [23:0] g, input logic [23:0] e);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input psc_word_t d);
      @(posedge core_clk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge core_clk_i);
      reg_wr_i <= 1'b0;
      reg_wdata_i <= ~d;
   endtask
   task automatic rd(input logic [7:0] a, input psc_word_t e);
      @(posedge core_clk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge core_clk_i);
      reg_rd_i <= 1'b0;
      #1 chk(reg_rdata_o, e);
   endtask
   // Decoded outputs trail the bank by a cycle; three edges is margin
   task automatic settle;
      repeat (3) @(posedge core_clk_i);
      #1;
   endtask
   task automatic t_down(input logic [2:0] s, input int n_exp);
      int n = 0;
      @(posedge core_clk_i);
      down_start_i <= 1'b1;
      down_step_i <= s;
      @(posedge core_clk_i);
      down_start_i <= 1'b0;
      // Count edges after the one that takes the start; a zero delay shows done at once
      #1 chk(down_busy_o, n_exp != 0);
      while (down_done_o !== 1'b1 && n < 200) begin
         @(posedge core_clk_i);
         #1 n++;
      end
      chk(n, n_exp);
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_regs;
      settle();
      chk(failsafe_out_n_o, 1'b1);
      chk(crc_err_o, 5'h1f);
      wr(8'h13, 24'hf12345);
      rd(8'h13, 24'h000000);
      @(posedge core_clk_i);
      user_prog_phase_one_i <= 1'b1;
      wr(8'h13, 24'hfabcd5);
      rd(8'h13, 24'h0abcd5);
      rd(8'h20, 24'h000000);
      wr(8'h11, 24'h0ffff0);
      rd(8'h11, 24'h0ff3f0);
      settle();
      chk(user_image_release_o, 16'habcd);
      chk(user_image_checksum_o, 8'hff);
      psc_nvm_model_i.load(8'h11, 24'h05a800);
      settle();
      chk(user_prog_state_bits_o, 2'b10);
      chk(user_image_checksum_o, 8'h5a);
   endtask
   task automatic t_boost;
      logic [1:0] c;
      for (int i = 0; i < 8; i++) begin
         c = i[1:0];
         wr(8'h14, {4'h0, c, c[0], c, 1'b0, i[2:0], c[0], c, 8'h00});
         settle();
         chk(boost_good_mv_o, 5500 + 1000 * c);
         chk(boost_level_mv_o, 6000 + 1000 * c);
         chk(bypass_mv_o, (c[0] ? 7000 : 6500) + 1000 * c);
         chk(supply_sense_mv_o, 5400 + 150 * c);
         chk(boost_timer_ms_o, tmr_tab[i]);
         chk(boost_crank_only_o, c[0]);
      end
   endtask
   task automatic t_pins;
      wr(8'h11, 24'h000090);
      @(posedge core_clk_i);
      deep_sleep_i <= 1'b1;
      failsafe_req_n_i <= 1'b0;
      sleep_req_i <= 1'b1;
      wake_flag_i <= 1'b1;
      settle();
      chk(failsafe_out_n_o, 1'b1);
      chk(boost_en_o, 1'b0);
      chk(sleep_grant_o, 1'b1);
      wr(8'h11, 24'h000000);
      wr(8'h14, 24'h004000);
      settle();
      chk(failsafe_out_n_o, 1'b0);
      chk(boost_en_o, 1'b1);
      chk(sleep_grant_o, 1'b0);
      @(posedge core_clk_i);
      boost_off_i <= 1'b1;
      settle();
      chk(boost_en_o, 1'b0);
   endtask
   task automatic t_up;
      wr(8'h10, 24'h000430);
      @(posedge core_clk_i);
      up_step_i <= 3'd7;
      settle();
      chk(up_hold_o, 1'b1);
      @(posedge core_clk_i);
      up_step_i <= 3'd6;
      settle();
      chk(up_hold_o, 1'b0);
      @(posedge core_clk_i);
      up_step_i <= 3'd2;
      settle();
      chk(up_hold_o, 1'b1);
      @(posedge core_clk_i);
      power_good_i <= 1'b1;
      settle();
      settle();
      chk(up_hold_o, 1'b0);
   endtask
   task automatic t_down_all;
      wr(8'h12, 24'h0c0010);
      settle();
      t_down(3'd1, 8);
      t_down(3'd2, 0);
      t_down(3'd0, 80);
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial begin
      repeat (2) @(posedge core_clk_i);
      reset_i <= 1'b0;
      t_regs();
      t_boost();
      t_pins();
      t_up();
      t_down_all();
      test_done();
   end
   // Whole run is under a thousand cycles; twenty thousand means a hang
   initial begin
      #1000000;
      bad_count++;
      test_done();
   end
endmodule
